// file: smpf_pkg.sv
package smpf_pkg;
	typedef enum logic [1:0] {
		SMPF_MODE_REG,
		SMPF_MODE_UART,
		SMPF_MODE_REPEATER
	} smpf_mode_e;
	typedef enum logic [1:0] {
		SMPF_ST_RESET,
		SMPF_ST_SAMPLE,
		SMPF_ST_RUN
	} smpf_state_e;
	localparam int SYNC_STAGES = 2;
	localparam int TUNE_W = 3;
	localparam int GP_COUNT = 3;
	localparam int GP_UART = 0;
	localparam int GP_DEBUG = 1;
	localparam int GP_INT = 2;
	localparam logic [1:0] FUNC_DEFAULT = 2'h0;
	localparam logic [1:0] FUNC_INPUT = 2'h1;
	localparam logic [1:0] FUNC_OUT_LOW = 2'h2;
	localparam logic [1:0] FUNC_OUT_HIGHZ = 2'h3;
	localparam logic [2:0] TUNE_RESET = 3'h0;
	localparam int SETTLE_NS = 200;
	localparam int CLK_NS = 100;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
endpackage : smpf_pkg

// file: smpf_if.sv
`timescale 1ns/10ps
`default_nettype none
interface smpf_if;
	logic [2:0] pin_raw;
	logic scl_raw;
	logic sda_raw;
	logic [2:0] pin_sync;
	logic scl_sync;
	logic sda_sync;
	modport src (input pin_raw, input scl_raw, input sda_raw,
		output pin_sync, output scl_sync, output sda_sync);
	modport snk (output pin_raw, output scl_raw, output sda_raw,
		input pin_sync, input scl_sync, input sda_sync);
endinterface : smpf_if
`default_nettype wire

// file: smpf_sync.sv
`timescale 1ns/10ps
`default_nettype none
module smpf_sync (
	input wire logic core_clk,
	input wire logic rst,
	smpf_if.src sif
);
	logic [4:0] meta_q;
	logic [4:0] stab_q;
	logic [4:0] meta_d;
	logic [4:0] stab_d;
	always_comb begin
		meta_d = {sif.sda_raw, sif.scl_raw, sif.pin_raw};
		stab_d = meta_q;
	end
	// only stab_q is read downstream
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_q <= 5'h00;
			stab_q <= 5'h00;
		end else begin
			meta_q <= meta_d;
			stab_q <= stab_d;
		end
	end
	assign sif.pin_sync = stab_q[2:0];
	assign sif.scl_sync = stab_q[3];
	assign sif.sda_sync = stab_q[4];
endmodule : smpf_sync
`default_nettype wire

// file: smpf_top.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// - register mode: third pin is open-drain active-low level interrupt output
// - strap modes: third pin is a configuration input right after reset
// - after reset in register mode the third pin is open-drain output, safe left floating
// - first and second pins are inputs at power-up, chip reset, soft reset
// - register mode: first pin low selects uart, high selects repeater
// - uart: usb d+ to embedded d+, embedded d- to usb d-
// - register mode: second pin is a debug input
// - strap uart: first pin low enables transfer; others high-impedance
// - register mode: software may override each pin function
// - strap repeater: three pins sampled at reset pick tuning setting
// - weak pull-downs on during reset, off once reset completes
// - after chip reset release repeater enabled in embedded default mode
module smpf_top (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic soft_rst,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic [2:0] gp_in,
	input wire logic irq_req,
	input wire logic [5:0] sw_func,
	input wire logic [2:0] sw_out,
	input wire logic usb_dp_in,
	input wire logic edn_in,
	output logic [2:0] gp_out,
	output logic [2:0] gp_oe,
	output logic pulldown_en,
	output logic [1:0] mode,
	output logic [2:0] tune_sel,
	output logic repeater_en,
	output logic uart_active,
	output logic edp_out,
	output logic dn_out,
	output logic debug_in,
	output logic strap_valid
);
	smpf_if sif ();
	smpf_pkg::smpf_state_e st_q;
	smpf_pkg::smpf_state_e st_d;
	logic [1:0] mode_q;
	logic [1:0] mode_d;
	logic [2:0] tune_q;
	logic [2:0] tune_d;
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	logic pd_q;
	logic pd_d;
	logic valid_q;
	logic valid_d;
	logic rep_q;
	logic rep_d;
	logic [2:0] out_q;
	logic [2:0] out_d;
	logic [2:0] oe_q;
	logic [2:0] oe_d;
	logic uart_q;
	logic uart_d;
	logic edp_q;
	logic edp_d;
	logic dn_q;
	logic dn_d;
	logic dbg_q;
	logic dbg_d;
	logic soft_q;
	logic soft_d;
	logic [1:0] dat_meta_q;
	logic [1:0] dat_meta_d;
	logic [1:0] dat_stab_q;
	logic [1:0] dat_stab_d;

	assign sif.pin_raw = gp_in;
	assign sif.scl_raw = scl_in;
	assign sif.sda_raw = sda_in;

	smpf_sync u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.sif(sif)
	);

	// uart data pins are asynchronous: two flops, only the second one is read
	always_comb begin
		dat_meta_d = {edn_in, usb_dp_in};
		dat_stab_d = dat_meta_q;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dat_meta_q <= 2'h0;
			dat_stab_q <= 2'h0;
		end else begin
			dat_meta_q <= dat_meta_d;
			dat_stab_q <= dat_stab_d;
		end
	end

	function automatic logic [1:0] decode_mode(input logic scl, input logic sda);
		if (!scl) begin
			decode_mode = smpf_pkg::SMPF_MODE_REPEATER;
		end else if (sda) begin
			decode_mode = smpf_pkg::SMPF_MODE_REG;
		end else begin
			decode_mode = smpf_pkg::SMPF_MODE_UART;
		end
	endfunction : decode_mode

	// sequencer: reset, settle the synchroniser, sample once, run
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		mode_d = mode_q;
		tune_d = tune_q;
		pd_d = pd_q;
		valid_d = valid_q;
		rep_d = rep_q;
		case (st_q)
			smpf_pkg::SMPF_ST_RESET: begin
				st_d = smpf_pkg::SMPF_ST_SAMPLE;
				cnt_d = 3'h0;
			end
			smpf_pkg::SMPF_ST_SAMPLE: begin
				// wait past two sync stages plus settle before trusting straps
				if (cnt_q == 3'(smpf_pkg::SETTLE_CYC + smpf_pkg::SYNC_STAGES)) begin
					mode_d = decode_mode(sif.scl_sync, sif.sda_sync);
					if (decode_mode(sif.scl_sync, sif.sda_sync) ==
						smpf_pkg::SMPF_MODE_REPEATER) begin
						tune_d = sif.pin_sync;
					end
					pd_d = 1'b0;
					valid_d = 1'b1;
					rep_d = 1'b1;
					st_d = smpf_pkg::SMPF_ST_RUN;
				end else begin
					cnt_d = cnt_q + 3'h1;
				end
			end
			smpf_pkg::SMPF_ST_RUN: begin
				st_d = st_q;
			end
			default: begin
				st_d = smpf_pkg::SMPF_ST_RESET;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_q <= smpf_pkg::SMPF_ST_RESET;
			cnt_q <= 3'h0;
			mode_q <= smpf_pkg::SMPF_MODE_REG;
			tune_q <= smpf_pkg::TUNE_RESET;
			pd_q <= 1'b1;
			valid_q <= 1'b0;
			rep_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			mode_q <= mode_d;
			tune_q <= tune_d;
			pd_q <= pd_d;
			valid_q <= valid_d;
			rep_q <= rep_d;
		end
	end

	// pin function; soft reset drops the first two pins back to input, clears uart_d and dbg_d, third pin stays interrupt
	always_comb begin
		out_d = 3'h0;
		oe_d = 3'h0;
		uart_d = 1'b0;
		dbg_d = 1'b0;
		soft_d = soft_rst;
		if (valid_q && !soft_q) begin
			case (smpf_pkg::smpf_mode_e'(mode_q))
				smpf_pkg::SMPF_MODE_REG: begin
					uart_d = !sif.pin_sync[smpf_pkg::GP_UART];
					dbg_d = sif.pin_sync[smpf_pkg::GP_DEBUG];
					oe_d[smpf_pkg::GP_INT] = irq_req;
					for (int i = 0; i < smpf_pkg::GP_COUNT; i++) begin
						case (sw_func[2*i +: 2])
							smpf_pkg::FUNC_INPUT: begin
								oe_d[i] = 1'b0;
							end
							smpf_pkg::FUNC_OUT_LOW: begin
								oe_d[i] = !sw_out[i];
							end
							smpf_pkg::FUNC_OUT_HIGHZ: begin
								oe_d[i] = 1'b0;
							end
							default: begin
								oe_d[i] = oe_d[i];
							end
						endcase
					end
				end
				smpf_pkg::SMPF_MODE_UART: begin
					uart_d = !sif.pin_sync[smpf_pkg::GP_UART];
				end
				default: begin
					uart_d = 1'b0;
				end
			endcase
		end else if (valid_q) begin
			oe_d[smpf_pkg::GP_INT] = (mode_q == smpf_pkg::SMPF_MODE_REG) && irq_req;
		end
	end

	// uart data: usb d+ to embedded d+, embedded d- to usb d-; sync costs two cycles
	always_comb begin
		edp_d = uart_d && dat_stab_q[0];
		dn_d = uart_d && dat_stab_q[1];
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			out_q <= 3'h0;
			oe_q <= 3'h0;
			uart_q <= 1'b0;
			edp_q <= 1'b0;
			dn_q <= 1'b0;
			dbg_q <= 1'b0;
			soft_q <= 1'b0;
		end else begin
			out_q <= out_d;
			oe_q <= oe_d;
			uart_q <= uart_d;
			edp_q <= edp_d;
			dn_q <= dn_d;
			dbg_q <= dbg_d;
			soft_q <= soft_d;
		end
	end

	assign gp_out = out_q;
	assign gp_oe = oe_q;
	assign pulldown_en = pd_q;
	assign mode = mode_q;
	assign tune_sel = tune_q;
	assign repeater_en = rep_q;
	assign uart_active = uart_q;
	assign edp_out = edp_q;
	assign dn_out = dn_q;
	assign debug_in = dbg_q;
	assign strap_valid = valid_q;

	mode_held_a: assert property (@(posedge core_clk) disable iff (rst)
		valid_q |=> $stable(mode_q) && $stable(tune_q))
		else $error("latched mode changed");
	pd_off_a: assert property (@(posedge core_clk) disable iff (rst)
		valid_q |-> !pd_q)
		else $error("pulldown on after sampling");
	pd_on_a: assert property (@(posedge core_clk) disable iff (rst)
		!valid_q |-> pd_q && !rep_q)
		else $error("pulldown off or repeater on before sampling");
	strap_no_drive_a: assert property (@(posedge core_clk) disable iff (rst)
		!valid_q |=> gp_oe == 3'h0)
		else $error("pin driven before straps sampled");
	uart_hiz_a: assert property (@(posedge core_clk) disable iff (rst)
		mode_q == smpf_pkg::SMPF_MODE_UART |-> gp_oe == 3'h0)
		else $error("pin driven in strap uart mode");
	irq_drive_a: assert property (@(posedge core_clk) disable iff (rst)
		valid_q && !soft_q && mode_q == smpf_pkg::SMPF_MODE_REG && irq_req
		&& sw_func[5:4] == smpf_pkg::FUNC_DEFAULT |=> gp_oe[2] && !gp_out[2])
		else $error("interrupt not driven low");
	drive_low_a: assert property (@(posedge core_clk) disable iff (rst)
		1'b1 |-> gp_out == 3'h0)
		else $error("pin driven high");
	soft_in_a: assert property (@(posedge core_clk) disable iff (rst)
		soft_q |=> gp_oe[1:0] == 2'h0)
		else $error("soft reset left pin driven");
	uart_path_a: assert property (@(posedge core_clk) disable iff (rst)
		!uart_q |-> !edp_out && !dn_out)
		else $error("uart path active while disabled");
	rep_on_a: assert property (@(posedge core_clk) disable iff (rst)
		$rose(valid_q) |-> rep_q)
		else $error("repeater not enabled at release");
	tune_clear_a: assert property (@(posedge core_clk) disable iff (rst)
		mode_q != smpf_pkg::SMPF_MODE_REPEATER |-> tune_q == smpf_pkg::TUNE_RESET)
		else $error("tuning set outside repeater mode");
	rep_hiz_a: assert property (@(posedge core_clk) disable iff (rst)
		mode_q == smpf_pkg::SMPF_MODE_REPEATER |-> gp_oe == 3'h0)
		else $error("pin driven in strap repeater mode");
	func_input_a: assert property (@(posedge core_clk) disable iff (rst)
		valid_q && !soft_q && mode_q == smpf_pkg::SMPF_MODE_REG
		&& sw_func[5:4] == smpf_pkg::FUNC_INPUT |=> !gp_oe[2])
		else $error("input function still drives pin");
	func_low_a: assert property (@(posedge core_clk) disable iff (rst)
		valid_q && !soft_q && mode_q == smpf_pkg::SMPF_MODE_REG
		&& sw_func[3:2] == smpf_pkg::FUNC_OUT_LOW |=> gp_oe[1] == !$past(sw_out[1]))
		else $error("output function level wrong");
	debug_follow_a: assert property (@(posedge core_clk) disable iff (rst)
		valid_q && !soft_q && mode_q == smpf_pkg::SMPF_MODE_REG
		|=> debug_in == $past(sif.pin_sync[smpf_pkg::GP_DEBUG]))
		else $error("debug input not followed");
	soft_irq_a: assert property (@(posedge core_clk) disable iff (rst)
		valid_q && soft_q && mode_q == smpf_pkg::SMPF_MODE_REG |=> gp_oe[2] == $past(irq_req))
		else $error("interrupt lost during soft reset");
endmodule : smpf_top
`default_nettype wire

// file: smpf_strap_model.sv
`timescale 1ns/10ps
`default_nettype none
// board straps plus host side: a strap bit means a pull-up is fitted
module smpf_strap_model (
	input wire logic [4:0] strap,
	input wire logic [2:0] gp_oe,
	output logic scl_in,
	output logic sda_in,
	output logic [2:0] gp_in
);
	// unstrapped pins settle low through pull-downs, never hold old value
	assign scl_in = strap[4];
	assign sda_in = strap[3];
	// open drain: an enabled pin wins over the pull-up
	assign gp_in = strap[2:0] & ~gp_oe;
endmodule : smpf_strap_model
`default_nettype wire

// file: strap_mode_pin_function_tb.sv
`timescale 1ns/10ps
`default_nettype none
module strap_mode_pin_function_tb;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic soft_rst = 1'b0;
	logic irq_req = 1'b0;
	logic [5:0] sw_func = 6'h00;
	logic [2:0] sw_out = 3'h7;
	logic usb_dp_in = 1'b1;
	logic edn_in = 1'b1;
	logic [4:0] strap = 5'h18;
	logic scl_in, sda_in;
	logic [2:0] gp_in, gp_out, gp_oe, tune_sel;
	logic [1:0] mode;
	logic pulldown_en, repeater_en, uart_active, edp_out, dn_out, debug_in, strap_valid;
	int n_fail = 0;
	int total_checks = 0;
	// straps, mode, tuning, uart active
	logic [10:0] rows [8] = '{11'h601, 11'h640, 11'h411, 11'h450,
		11'h16A, 11'h3EE, 11'h020, 11'h0A4};
	always #50 core_clk = ~core_clk;
	smpf_strap_model model (.strap(strap), .gp_oe(gp_oe), .scl_in(scl_in), .sda_in(sda_in),
		.gp_in(gp_in));
	smpf_top dut (.core_clk(core_clk), .rst(rst), .soft_rst(soft_rst), .scl_in(scl_in),
		.sda_in(sda_in), .gp_in(gp_in), .irq_req(irq_req), .sw_func(sw_func),
		.sw_out(sw_out), .usb_dp_in(usb_dp_in), .edn_in(edn_in), .gp_out(gp_out),
		.gp_oe(gp_oe), .pulldown_en(pulldown_en), .mode(mode), .tune_sel(tune_sel),
		.repeater_en(repeater_en), .uart_active(uart_active), .edp_out(edp_out),
		.dn_out(dn_out), .debug_in(debug_in), .strap_valid(strap_valid));
	task automatic end_sim();
		if (n_fail == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask : cyc
	// straps held stable from release through sampling
	task automatic do_reset(input logic [4:0] s);
		@(posedge core_clk);
		rst <= 1'b1;
		strap <= s;
		cyc(20);
		chk(8'(pulldown_en), 8'h01);
		chk(8'(strap_valid), 8'h00);
		chk(8'(gp_oe), 8'h00);
		@(posedge core_clk);
		rst <= 1'b0;
		cyc(12);
	endtask : do_reset
	initial begin
		#(100 * 3000);
		n_fail++;
		end_sim();
	end
	initial begin
		foreach (rows[i]) begin
			do_reset(rows[i][10:6]);
			chk(8'(mode), 8'(rows[i][5:4]));
			chk(8'(tune_sel), 8'(rows[i][3:1]));
			chk(8'(uart_active), 8'(rows[i][0]));
			chk(8'({edp_out, dn_out}), 8'({2{rows[i][0]}}));
			chk(8'(gp_oe), 8'h00);
			chk(8'(gp_out), 8'h00);
			chk(8'({pulldown_en, repeater_en, strap_valid}), 8'h03);
		end
		// strap uart mode ignores interrupt and software pin settings
		do_reset(5'h10);
		@(posedge core_clk);
		irq_req <= 1'b1;
		sw_func <= 6'h2A;
		sw_out <= 3'h0;
		cyc(4);
		chk(8'(gp_oe), 8'h00);
		chk(8'({edp_out, dn_out}), 8'h03);
		@(posedge core_clk);
		strap <= 5'h11;
		cyc(5);
		chk(8'(uart_active), 8'h00);
		chk(8'({edp_out, dn_out}), 8'h00);
		chk(8'(mode), 8'h01);
		@(posedge core_clk);
		irq_req <= 1'b0;
		sw_func <= 6'h00;
		sw_out <= 3'h7;
		do_reset(5'h18);
		chk(8'({edp_out, dn_out}), 8'h03);
		@(posedge core_clk);
		usb_dp_in <= 1'b0;
		strap <= 5'h1A;
		cyc(5);
		chk(8'({edp_out, dn_out}), 8'h01);
		chk(8'(debug_in), 8'h01);
		// pins moving after sampling must not retune
		@(posedge core_clk);
		strap <= 5'h07;
		cyc(5);
		chk(8'(mode), 8'h00);
		chk(8'(tune_sel), 8'h00);
		chk(8'(uart_active), 8'h00);
		@(posedge core_clk);
		strap <= 5'h1F;
		irq_req <= 1'b1;
		cyc(4);
		chk(8'(gp_oe[2]), 8'h01);
		chk(8'(gp_in[2]), 8'h00);
		@(posedge core_clk);
		sw_func <= 6'h10;
		cyc(2);
		chk(8'(gp_oe[2]), 8'h00);
		@(posedge core_clk);
		irq_req <= 1'b0;
		sw_func <= 6'h08;
		sw_out <= 3'h5;
		cyc(4);
		chk(8'(gp_oe), 8'h02);
		@(posedge core_clk);
		soft_rst <= 1'b1;
		irq_req <= 1'b1;
		cyc(2);
		chk(8'(gp_oe), 8'h04);
		chk(8'(mode), 8'h00);
		@(posedge core_clk);
		soft_rst <= 1'b0;
		irq_req <= 1'b0;
		sw_func <= 6'h00;
		cyc(4);
		chk(8'(gp_oe), 8'h00);
		// chip reset while a pin is driven
		@(posedge core_clk);
		sw_func <= 6'h08;
		sw_out <= 3'h5;
		cyc(2);
		chk(8'(gp_oe), 8'h02);
		do_reset(5'h18);
		chk(8'(gp_oe), 8'h02);
		end_sim();
	end
endmodule : strap_mode_pin_function_tb
`default_nettype wire
